// *** logic/iarr_pkg.sv ***
// Types shared by the alias remapper files.
// Assumes the register header sits in the include path.
package iarr_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } iarr_reg_req_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] addr;
        logic       rnw;
    } iarr_i2c_addr_t;

    typedef struct packed {
        logic       fwd;
        logic [6:0] addr;
        logic       rnw;
        logic       self_ack;
        logic       local_hit;
    } iarr_fwd_t;

    typedef enum logic [1:0] {IARR_IDLE, IARR_FWD, IARR_LOCAL} iarr_state_t;
endpackage

// *** logic/iarr_port_regs.sv ***
// One receive port's copy of the alias register and the three target registers.
// Assumes writes are already qualified by the port select in the parent.
`timescale 1ns/1ps
`include "iarr_regs.svh"
module iarr_port_regs (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic                  wr_en,
    input  wire logic [7:0]            wr_addr,
    input  wire logic [7:0]            wr_data,
    output logic [7:0]                 alias_q,
    output logic [`IARR_NUM_TARGETS*8-1:0] target_q
);
    logic hit_alias;
    logic hit_t0;
    logic hit_t1;
    logic hit_t2;
    assign hit_alias = wr_en && (wr_addr == `IARR_SER_ALIAS_OFS);
    assign hit_t0    = wr_en && (wr_addr == `IARR_TARGET0_OFS);
    assign hit_t1    = wr_en && (wr_addr == `IARR_TARGET1_OFS);
    assign hit_t2    = wr_en && (wr_addr == `IARR_TARGET2_OFS);

    // Bit 0 of a target register is reserved and always holds zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            alias_q  <= `IARR_RESET_VAL;
            target_q <= '0;
        end else begin
            if (hit_alias) alias_q <= wr_data;
            if (hit_t0) target_q[7:0]   <= {wr_data[7:1], 1'b0};
            if (hit_t1) target_q[15:8]  <= {wr_data[7:1], 1'b0};
            if (hit_t2) target_q[23:16] <= {wr_data[7:1], 1'b0};
        end
    end
endmodule

// *** logic/iarr_regs.svh ***
// Register offsets, field positions, reset values and link constants of the alias remapper.
// Assumes inclusion by the port register and top design files through its bare name.
`ifndef IARR_REGS_SVH
`define IARR_REGS_SVH
`define IARR_PORT_SEL_OFS      8'h4C
`define IARR_SER_ALIAS_OFS     8'h5C
`define IARR_TARGET0_OFS       8'h5D
`define IARR_TARGET1_OFS       8'h5E
`define IARR_TARGET2_OFS       8'h5F
`define IARR_BCC_CONFIG_OFS    8'h58
`define IARR_PASS_BIT          6
`define IARR_AUTO_ACK_BIT      0
`define IARR_ADDR_MSB          7
`define IARR_ADDR_LSB          1
`define IARR_RESET_VAL         8'h00
`define IARR_PORT_SEL_RESET    8'h01
`define IARR_NUM_PORTS         4
`define IARR_NUM_TARGETS       3
`endif

// *** logic/iarr_top.sv ***
// Alias decoder and remapper for the receive ports of the control channel.
// Assumes the local I2C slave front end decodes address bytes in REF_CLK and
// presents them as one-cycle strobes; the register port is a same-clock strobe.
`timescale 1ns/1ps
`include "iarr_regs.svh"
module iarr_top (
    input  wire logic                   REF_CLK,
    input  wire logic                   RSTN,
    input  wire iarr_pkg::iarr_reg_req_t REG_REQ,
    output logic [7:0]                  REG_RDATA,
    input  wire logic [1:0]             RX_PORT,
    input  wire iarr_pkg::iarr_i2c_addr_t I2C_ADDR,
    input  wire logic [`IARR_NUM_TARGETS*7-1:0] TARGET_ALIAS,
    output iarr_pkg::iarr_fwd_t         FWD
);
    import iarr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register access: port select and shared pass-through control.
    logic [7:0] port_sel_q;
    logic [7:0] bcc_q;
    logic       wr_sel;
    logic       wr_bcc;
    assign wr_sel = REG_REQ.wr && (REG_REQ.addr == `IARR_PORT_SEL_OFS);
    assign wr_bcc = REG_REQ.wr && (REG_REQ.addr == `IARR_BCC_CONFIG_OFS);

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
            port_sel_q <= `IARR_PORT_SEL_RESET;
            bcc_q      <= `IARR_RESET_VAL;
        end else begin
            if (wr_sel) port_sel_q <= REG_REQ.wdata;
            if (wr_bcc) bcc_q <= REG_REQ.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-port register copies; a write reaches every port whose select bit is set.
    logic [7:0]  alias_q  [`IARR_NUM_PORTS];
    logic [23:0] target_q [`IARR_NUM_PORTS];
    logic [7:0]  rd_mux;
    logic [1:0]  rd_port;

    genvar gp;
    generate
        for (gp = 0; gp < `IARR_NUM_PORTS; gp++) begin : g_port
            iarr_port_regs u_regs (
                .clk      (REF_CLK),
                .rst_n    (RSTN),
                .wr_en    (REG_REQ.wr && port_sel_q[gp]),
                .wr_addr  (REG_REQ.addr),
                .wr_data  (REG_REQ.wdata),
                .alias_q  (alias_q[gp]),
                .target_q (target_q[gp])
            );
        end
    endgenerate

    // Reads come from the lowest selected port, so a multi-port select reads one copy.
    assign rd_port = port_sel_q[0] ? 2'h0 : port_sel_q[1] ? 2'h1 :
                     port_sel_q[2] ? 2'h2 : 2'h3;

    always_comb begin
        case (REG_REQ.addr)
            `IARR_PORT_SEL_OFS:   rd_mux = port_sel_q;
            `IARR_BCC_CONFIG_OFS: rd_mux = bcc_q;
            `IARR_SER_ALIAS_OFS:  rd_mux = alias_q[rd_port];
            `IARR_TARGET0_OFS:    rd_mux = target_q[rd_port][7:0];
            `IARR_TARGET1_OFS:    rd_mux = target_q[rd_port][15:8];
            `IARR_TARGET2_OFS:    rd_mux = target_q[rd_port][23:16];
            default:              rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) REG_RDATA <= 8'h00;
        else if (REG_REQ.rd) REG_RDATA <= rd_mux;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Address decode for the port that owns this transaction.
    logic [7:0]  cur_alias;
    logic [23:0] cur_target;
    logic [6:0]  ser_alias;
    logic        ser_hit;
    logic [2:0]  tgt_hit;
    logic        any_hit;
    logic [6:0]  remap;
    logic        pass_en;
    iarr_fwd_t   fwd_d;

    assign cur_alias  = alias_q[RX_PORT];
    assign cur_target = target_q[RX_PORT];
    assign ser_alias  = cur_alias[`IARR_ADDR_MSB:`IARR_ADDR_LSB];
    assign pass_en    = bcc_q[`IARR_PASS_BIT];
    // A zero alias never decodes, which also keeps general call out of the remote path.
    assign ser_hit    = (ser_alias != 7'h00) && (I2C_ADDR.addr == ser_alias);

    genvar gt;
    generate
        for (gt = 0; gt < `IARR_NUM_TARGETS; gt++) begin : g_tgt
            assign tgt_hit[gt] = (TARGET_ALIAS[gt*7 +: 7] != 7'h00) &&
                                 (I2C_ADDR.addr == TARGET_ALIAS[gt*7 +: 7]);
        end
    endgenerate

    assign any_hit = ser_hit || (|tgt_hit);

    // Serializer alias maps to target 0; slave alias n maps to target n.
    assign remap = tgt_hit[1] ? cur_target[15:9] :
                   tgt_hit[2] ? cur_target[23:17] :
                   cur_target[7:1];

    always_comb begin
        fwd_d           = '0;
        fwd_d.rnw       = I2C_ADDR.rnw;
        fwd_d.addr      = remap;
        fwd_d.fwd       = I2C_ADDR.valid && any_hit && pass_en;
        fwd_d.self_ack  = I2C_ADDR.valid && ser_hit && !I2C_ADDR.rnw &&
                          cur_alias[`IARR_AUTO_ACK_BIT];
        fwd_d.local_hit = I2C_ADDR.valid && !any_hit;
    end

    always_ff @(posedge REF_CLK) begin
        if (!RSTN) FWD <= '0;
        else FWD <= fwd_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    property p_zero_alias;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && ser_alias == 7'h00 && tgt_hit == 3'b000) |=> !FWD.fwd;
    endproperty
    a_zero_alias: assert property (p_zero_alias) else $error("zero alias forwarded");

    property p_pass_gate;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && ser_hit && !pass_en) |=> !FWD.fwd;
    endproperty
    a_pass_gate: assert property (p_pass_gate) else $error("forward while pass off");

    property p_pass_fwd;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && ser_hit && pass_en) |=> FWD.fwd;
    endproperty
    a_pass_fwd: assert property (p_pass_fwd) else $error("match not forwarded");

    property p_remap0;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && ser_hit && tgt_hit == 3'b000 && pass_en)
            |=> FWD.addr == $past(cur_target[7:1]);
    endproperty
    a_remap0: assert property (p_remap0) else $error("bad remap address");

    property p_remap_n;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && tgt_hit == 3'b100 && pass_en)
            |=> FWD.addr == $past(cur_target[23:17]);
    endproperty
    a_remap_n: assert property (p_remap_n) else $error("bad target n remap");

    property p_self_ack;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && ser_hit && !I2C_ADDR.rnw) |=>
            FWD.self_ack == $past(cur_alias[0]);
    endproperty
    a_self_ack: assert property (p_self_ack) else $error("auto ack wrong");

    property p_no_match;
        @(posedge REF_CLK) disable iff (!RSTN)
        (I2C_ADDR.valid && !ser_hit && tgt_hit == 3'b000) |=> FWD.local_hit && !FWD.fwd;
    endproperty
    a_no_match: assert property (p_no_match) else $error("unmatched forwarded");

    property p_alias_store;
        @(posedge REF_CLK) disable iff (!RSTN)
        (wr_sel == 1'b0 && REG_REQ.wr && REG_REQ.addr == `IARR_SER_ALIAS_OFS && port_sel_q[0])
            |=> alias_q[0] == $past(REG_REQ.wdata);
    endproperty
    a_alias_store: assert property (p_alias_store) else $error("alias not stored");

    property p_target_lsb;
        @(posedge REF_CLK) disable iff (!RSTN)
        1'b1 |-> target_q[RX_PORT][0] == 1'b0 && target_q[RX_PORT][8] == 1'b0 &&
                 target_q[RX_PORT][16] == 1'b0;
    endproperty
    a_target_lsb: assert property (p_target_lsb) else $error("reserved bit set");

    property p_sel_guard;
        @(posedge REF_CLK) disable iff (!RSTN)
        (REG_REQ.wr && REG_REQ.addr == `IARR_SER_ALIAS_OFS && !port_sel_q[1])
            |=> $stable(alias_q[1]);
    endproperty
    a_sel_guard: assert property (p_sel_guard) else $error("unselected port written");

    c_fwd:   cover property (@(posedge REF_CLK) disable iff (!RSTN) FWD.fwd);
    c_ack:   cover property (@(posedge REF_CLK) disable iff (!RSTN) FWD.self_ack);
    c_local: cover property (@(posedge REF_CLK) disable iff (!RSTN) FWD.local_hit);
endmodule

// *** sim/iarr_host_model.sv ***
// Local host model: presents decoded address strobes and captures the forwarded result.
// Assumes the bench calls send only after reset has been released.
`timescale 1ns/1ps
module iarr_host_model (
    input  wire logic              clk,
    input  wire iarr_pkg::iarr_fwd_t fwd,
    output iarr_pkg::iarr_i2c_addr_t i2c_addr,
    output logic [1:0]             rx_port
);
    import iarr_pkg::*;
    iarr_fwd_t seen;
    initial begin
        i2c_addr = '0;
        rx_port  = 2'h0;
    end
    // The address is inverted on release, so a stale byte never passes for a live one.
    task automatic send(input logic [6:0] a, input logic rnw, input logic [1:0] port);
        @(posedge clk) #1;
        rx_port  = port;
        i2c_addr = '{valid: 1'b1, addr: a, rnw: rnw};
        @(posedge clk) #1;
        i2c_addr = '{valid: 1'b0, addr: ~a, rnw: ~rnw};
        seen     = fwd;
    endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench of the alias remapper, one task for each scenario.
// Assumes the host model drives the address strobes; the bench drives registers.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    import iarr_pkg::*;
    logic            REF_CLK = 1'b0;
    logic            RSTN    = 1'b0;
    iarr_reg_req_t   REG_REQ = '0;
    logic [7:0]      REG_RDATA;
    logic [1:0]      RX_PORT;
    iarr_i2c_addr_t  I2C_ADDR;
    logic [20:0]     TARGET_ALIAS = '0;
    iarr_fwd_t       FWD;
    int              n_errors = 0;
    int              samples_checked = 0;
    int              cyc = 0;
    always #5 REF_CLK = ~REF_CLK;
    iarr_top iarr_top_i (.REF_CLK(REF_CLK), .RSTN(RSTN), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .RX_PORT(RX_PORT), .I2C_ADDR(I2C_ADDR),
        .TARGET_ALIAS(TARGET_ALIAS), .FWD(FWD));
    iarr_host_model iarr_host_model_i (.clk(REF_CLK), .fwd(FWD), .i2c_addr(I2C_ADDR),
        .rx_port(RX_PORT));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge REF_CLK) #1;
        REG_REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge REF_CLK) #1;
        REG_REQ = '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge REF_CLK) #1;
        REG_REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge REF_CLK) #1;
        REG_REQ = '0;
        `CHK("rdata", e, REG_RDATA)
    endtask
    // Sends one address byte and judges the forwarded result one cycle later.
    task automatic go(input logic [6:0] a, input logic rnw, input logic [1:0] p,
                      input logic f, input logic [6:0] ea, input logic sa, input logic lh);
        iarr_fwd_t s;
        iarr_host_model_i.send(a, rnw, p);
        s = iarr_host_model_i.seen;
        `CHK("fwd", f, s.fwd)
        if (f) `CHK("addr", ea, s.addr)
        `CHK("rnw", rnw, s.rnw)
        `CHK("self_ack", sa, s.self_ack)
        `CHK("local_hit", lh, s.local_hit)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd(8'h5C, 8'h00);
        rd(8'h5D, 8'h00);
        rd(8'h5E, 8'h00);
        rd(8'h5F, 8'h00);
        rd(8'h4C, 8'h01);
        rd(8'h70, 8'h00);
        $display("t_reset done");
    endtask
    task automatic t_regs;
        wr(8'h5C, 8'h51);
        wr(8'h5D, 8'hA5);
        wr(8'h5E, 8'h22);
        wr(8'h5F, 8'h7B);
        wr(8'h70, 8'hFF);
        rd(8'h5C, 8'h51);
        rd(8'h5D, 8'hA4);
        rd(8'h5E, 8'h22);
        rd(8'h5F, 8'h7A);
        rd(8'h70, 8'h00);
        $display("t_regs done");
    endtask
    task automatic t_fwd;
        go(7'h28, 1'b0, 2'h0, 1'b0, 7'h00, 1'b1, 1'b0);
        wr(8'h58, 8'h40);
        go(7'h28, 1'b0, 2'h0, 1'b1, 7'h52, 1'b1, 1'b0);
        go(7'h28, 1'b1, 2'h0, 1'b1, 7'h52, 1'b0, 1'b0);
        go(7'h33, 1'b0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b1);
        $display("t_fwd done");
    endtask
    task automatic t_slave;
        TARGET_ALIAS = {7'h19, 7'h15, 7'h00};
        go(7'h15, 1'b0, 2'h0, 1'b1, 7'h11, 1'b0, 1'b0);
        go(7'h19, 1'b1, 2'h0, 1'b1, 7'h3D, 1'b0, 1'b0);
        go(7'h00, 1'b0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b1);
        $display("t_slave done");
    endtask
    // Ports 2 and 3 share one write, so both copies must decode the same alias.
    task automatic t_port;
        wr(8'h4C, 8'h02);
        rd(8'h5C, 8'h00);
        go(7'h28, 1'b0, 2'h1, 1'b0, 7'h00, 1'b0, 1'b1);
        go(7'h28, 1'b0, 2'h0, 1'b1, 7'h52, 1'b1, 1'b0);
        wr(8'h4C, 8'h0C);
        wr(8'h5C, 8'h31);
        wr(8'h5D, 8'h40);
        rd(8'h5C, 8'h31);
        rd(8'h5D, 8'h40);
        go(7'h18, 1'b0, 2'h3, 1'b1, 7'h20, 1'b1, 1'b0);
        go(7'h18, 1'b1, 2'h2, 1'b1, 7'h20, 1'b0, 1'b0);
        go(7'h18, 1'b0, 2'h0, 1'b0, 7'h00, 1'b0, 1'b1);
        wr(8'h4C, 8'h01);
        rd(8'h5C, 8'h51);
        wr(8'h5C, 8'h50);
        go(7'h28, 1'b0, 2'h0, 1'b1, 7'h52, 1'b0, 1'b0);
        $display("t_port done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // The whole run needs some 85 cycles; the ceiling leaves ample margin.
    always @(posedge REF_CLK) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            finish_test();
        end
    end
    initial begin
        repeat (5) @(posedge REF_CLK);
        #1 RSTN = 1'b1;
        t_reset();
        t_regs();
        t_fwd();
        t_slave();
        t_port();
        finish_test();
    end
endmodule
